/* tb/sdci_core_properties.sv */
// Purpose: port-level checks of the sdram command block
// Assumes: one clk_i domain; ck_i at 160 ns against a 20 ns clk_i
// Notes:   burst windows allow for the link clock phase and sync delay
`timescale 1ns/1ps
`include "sdci_defines.vh"

module sdci_core_properties (
    input wire        clk_i,
    input wire        resetn_i,
    input wire        cke_i,
    input wire [3:0]  cmd_i,
    input wire        core_rd_o,
    input wire        dq_oe_o,
    input wire        burst_busy_o,
    input wire        burst_chop_o,
    input wire        refresh_o,
    input wire        zq_long_o,
    input wire        zq_short_o,
    input wire        proto_err_o,
    input wire        nop_seen_o,
    input wire        odt_hiz_o,
    input wire [17:0] third_mode_register_o,
    input wire [17:0] fourth_mode_register_o,
    input wire [17:0] fifth_mode_register_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // ==========================================================
    // reset defaults and termination
    a_reset_defaults:
    assert property ($rose(resetn_i) |-> odt_hiz_o && third_mode_register_o == 18'h00000
        && fourth_mode_register_o == 18'h00000 && fifth_mode_register_o == 18'h00000)
        else $error("mode defaults or termination wrong after reset");
    a_odt_hold:
    assert property (odt_hiz_o && !cke_i && !$past(cke_i) |=> odt_hiz_o)
        else $error("termination left high impedance before clock enable");
    a_odt_release:
    assert property (cke_i [*3] |-> !odt_hiz_o)
        else $error("termination still high impedance after clock enable");

    // ==========================================================
    // command effects
    a_read_starts_burst:
    assert property (core_rd_o |-> burst_busy_o && dq_oe_o)
        else $error("read accepted without a running burst");
    a_error_no_access:
    assert property (proto_err_o |-> !core_rd_o)
        else $error("refused read still reached the core");
    a_refresh_cause:
    assert property (refresh_o |-> $past(cmd_i) == `SDCI_CMD_REF)
        else $error("refresh pulse without refresh command");
    a_zq_cause:
    assert property (zq_long_o || zq_short_o |-> $past(cmd_i) ==
        (zq_long_o ? `SDCI_CMD_ZQCL : `SDCI_CMD_ZQCS))
        else $error("calibration pulse without matching command");
    a_nop_cause:
    assert property (nop_seen_o |-> $past(cmd_i) == `SDCI_CMD_NOP)
        else $error("nop pulse without nop command");

    // burst length: four beats span about 16 cycles, eight about 32
    a_chop_length:
    assert property ($rose(burst_busy_o) && burst_chop_o |->
        burst_busy_o [*8] ##[4:16] !burst_busy_o)
        else $error("chopped burst of wrong length");
    a_full_length:
    assert property ($rose(burst_busy_o) && !burst_chop_o |->
        burst_busy_o [*8] ##[20:32] !burst_busy_o)
        else $error("full burst of wrong length");

    c_chop_read: cover property (core_rd_o && burst_chop_o);
    c_full_read: cover property (core_rd_o && !burst_chop_o);
    c_refused: cover property (proto_err_o);
endmodule // sdci_core_properties

bind sdci_core sdci_core_properties sdci_core_properties_i (.*);

/* tb/sdci_ctrl_model.sv */
// Purpose: far-side controller model: link clock and data words
// Assumes: the command clock runs free once started
// Notes:   phase is offset so it never lines up with clk_i
`timescale 1ns/1ps

module sdci_ctrl_model #(
    parameter        HALF_NS = 80,
    parameter [63:0] WORD    = 64'h8877665544332211
) (
    output reg         ck_o,
    output wire [63:0] rdata_o,
    output wire [63:0] wdata_o
);
    // clock started long before clock enable rises
    initial begin
        ck_o = 1'b0;
        #37;
        forever #(HALF_NS) ck_o = ~ck_o;
    end
    // distinct bytes so each beat is visible on the data pins
    assign rdata_o = WORD;
    assign wdata_o = ~WORD;
endmodule // sdci_ctrl_model

/* tb/sdram_command_and_init_test.sv */
// Purpose: self-checking bench of the sdram command block
// Assumes: x8 organisation, 20 ns clk_i, 160 ns link clock
// Notes:   bursts are judged by beats seen on dq_o
`timescale 1ns/1ps
`include "sdci_defines.vh"

module sdram_command_and_init_test;
    reg clk_i, resetn_i, cke_i, boundary_scan_enable_i, crc_en_i;
    reg [3:0] cmd_i;
    reg [1:0] bg_i, ba_i;
    reg [17:0] addr_i;
    wire ck_i, core_rd_o, core_wr_o, dq_oe_o, burst_busy_o, burst_chop_o, auto_pre_o;
    wire write_crc_o, refresh_o, zq_long_o, zq_short_o, odt_hiz_o, proto_err_o, nop_seen_o;
    wire [3:0] core_bank_o;
    wire [17:0] core_row_o, third_mode_register_o, fourth_mode_register_o;
    wire [17:0] fifth_mode_register_o;
    wire [9:0] core_col_o;
    wire [63:0] wdata_i, rdata_i, core_wdata_o;
    wire [7:0] dq_o;
    reg [7:0] last;
    reg       last_oe;
    integer fails, n_checks, nb;
    reg wr_seen, crc_seen;

    sdci_core sdci_core_i (.*);
    sdci_ctrl_model sdci_ctrl_model_i (.ck_o(ck_i), .rdata_o(rdata_i), .wdata_o(wdata_i));

    // ==========================================================
    // clock, reset and watchdog
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        fails = fails + 1;
        end_sim;
    end

    // beat monitor: each new dq_o value is the next byte, low byte first
    // the last beat lands on the edge that drops dq_oe_o, so one more cycle counts
    always @(posedge clk_i) begin
        last <= dq_o;
        last_oe <= dq_oe_o;
        if (core_wr_o) wr_seen = 1'b1;
        if (write_crc_o) crc_seen = 1'b1;
        if ((dq_oe_o || last_oe === 1'b1) && dq_o !== last) begin
            chk("beat", dq_o, rdata_i[(nb % 8) * 8 +: 8]);
            nb = nb + 1;
        end
    end

    task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one command cycle, then deselect; returns just after the taking edge
    task issue(input [3:0] c, input [3:0] bk, input [17:0] a);
        @(posedge clk_i);
        cmd_i <= c;
        {bg_i, ba_i} <= bk;
        addr_i <= a;
        @(posedge clk_i);
        cmd_i <= `SDCI_CMD_DES;
        #1;
    endtask

    task wait_idle;
        integer i;
        for (i = 0; i < 100 && burst_busy_o !== 1'b0; i = i + 1) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
        #1;
        chk("busy", burst_busy_o, 0);
    endtask

    task do_reset;
        @(posedge clk_i);
        cke_i <= 1'b0;
        resetn_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1;
        chk("mr3", third_mode_register_o, 0);
        chk("mr4", fourth_mode_register_o, 0);
        chk("mr5", fifth_mode_register_o, 0);
        chk("odt", odt_hiz_o, 1);
        issue(`SDCI_CMD_REF, 4'h0, 18'h00000);
        chk("ref before cke", refresh_o, 0);
        repeat (40) @(posedge clk_i);
        cke_i <= 1'b1; // deselect stands on cmd_i here
        repeat (3) @(posedge clk_i);
        #1;
        chk("odt", odt_hiz_o, 0);
        $display("reset test done");
    endtask

    task t_cmds;
        integer i;
        logic [3:0] tbl [0:3];
        tbl = '{`SDCI_CMD_REF, `SDCI_CMD_ZQCL, `SDCI_CMD_ZQCS, `SDCI_CMD_NOP};
        for (i = 0; i < 4; i = i + 1) begin
            issue(tbl[i], 4'h0, 18'h00000);
            chk("pulses", {refresh_o, zq_long_o, zq_short_o, nop_seen_o}, 4'h8 >> i);
        end
        @(posedge clk_i) boundary_scan_enable_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        issue(`SDCI_CMD_REF, 4'h0, 18'h00000);
        chk("ref in scan", refresh_o, 0);
        @(posedge clk_i) boundary_scan_enable_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        $display("command test done");
    endtask

    task t_mrs;
        issue(`SDCI_CMD_MRS, 4'h3, 18'h2A5A5);
        issue(`SDCI_CMD_MRS, 4'h4, 18'h15A5A);
        issue(`SDCI_CMD_MRS, 4'h5, 18'h00007);
        chk("mr3", third_mode_register_o, 18'h2A5A5);
        chk("mr4", fourth_mode_register_o, 18'h15A5A);
        chk("mr5", fifth_mode_register_o, 18'h00007);
        issue(`SDCI_CMD_RD, 4'h9, 18'h00000);
        chk("closed err", proto_err_o, 1);
        chk("closed rd", core_rd_o, 0);
        $display("mode and refusal test done");
    endtask

    // open a row, read it, count the beats
    task rd_burst(input [3:0] bk, input [17:0] row, input [17:0] a, input [3:0] beats);
        issue(`SDCI_CMD_ACT, bk, row);
        nb = 0;
        issue(`SDCI_CMD_RD, bk, a);
        chk("rd pulse", core_rd_o, 1);
        chk("bank", core_bank_o, bk);
        chk("row", core_row_o, row);
        chk("col", core_col_o, a[9:0]);
        chk("auto pre", auto_pre_o, a[10]);
        chk("chop", burst_chop_o, beats == 4);
        wait_idle;
        chk("beats", nb, beats);
    endtask

    task t_reads;
        rd_burst(4'hB, 18'h3FFFF, 18'h000F3, 8);
        issue(`SDCI_CMD_MRS, 4'h0, 18'h00001);
        rd_burst(4'h5, 18'h00123, 18'h00010, 4);
        rd_burst(4'h5, 18'h00124, 18'h01411, 8);
        repeat (2) @(posedge clk_i);
        issue(`SDCI_CMD_RD, 4'h5, 18'h00000);
        chk("closed by ap", proto_err_o, 1);
        issue(`SDCI_CMD_MRS, 4'h0, 18'h00002);
        rd_burst(4'hF, 18'h00000, 18'h01000, 4);
        issue(`SDCI_CMD_MRS, 4'h0, 18'h00000);
        $display("read test done");
    endtask

    task t_write;
        issue(`SDCI_CMD_ACT, 4'h2, 18'h00042);
        wr_seen = 1'b0;
        crc_seen = 1'b0;
        crc_en_i <= 1'b1;
        issue(`SDCI_CMD_WR, 4'h2, 18'h00408);
        crc_en_i <= 1'b0;
        wait_idle;
        chk("wr pulse", wr_seen, 1);
        chk("crc", crc_seen, 1);
        chk("wdata", core_wdata_o, wdata_i);
        chk("wr bank", core_bank_o, 4'h2);
        $display("write test done");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        fails = 0;
        n_checks = 0;
        nb = 0;
        resetn_i = 1'b0;
        cke_i = 1'b0;
        boundary_scan_enable_i = 1'b0;
        crc_en_i = 1'b0;
        cmd_i = `SDCI_CMD_DES;
        bg_i = 2'h0;
        ba_i = 2'h0;
        addr_i = 18'h00000;
        do_reset;
        t_cmds;
        t_mrs;
        t_reads;
        t_write;
        do_reset;
        end_sim;
    end
endmodule // sdram_command_and_init_test

/* verilog/sdci_bank_table.v */
// Purpose: per-bank open-row table of the sdram command block
// Assumes: one command per clock, bank index already formed
// Notes:   one generate loop holds a valid flag and row per bank
`timescale 1ns/1ps

module sdci_bank_table #(
    parameter NBANK = 16,
    parameter BW    = 4,
    parameter RW    = 18
) (
    input  wire          clk_i,
    input  wire          resetn_i,
    input  wire          open_i,
    input  wire          close_i,
    input  wire          close_all_i,
    input  wire [BW-1:0] bank_i,
    input  wire [RW-1:0] row_i,
    output wire          is_open_o,
    output wire [RW-1:0] row_o
);

    wire [NBANK-1:0] open_vec;
    wire [RW-1:0]    rows [0:NBANK-1];

    // ==========================================================
    // per-bank state
    genvar g;
    generate
        for (g = 0; g < NBANK; g = g + 1) begin : g_bank
            reg          valid_reg;
            reg [RW-1:0] row_reg;
            localparam [BW-1:0] IDX = g;
            wire         hit = (bank_i == IDX);
            // close wins only when no open is aimed at this bank
            always @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    valid_reg <= 1'b0;
                    row_reg   <= {RW{1'b0}};
                end else if (open_i && hit) begin
                    valid_reg <= 1'b1;
                    row_reg   <= row_i;
                end else if (close_all_i || (close_i && hit)) begin
                    valid_reg <= 1'b0;
                end
            end
            assign open_vec[g] = valid_reg;
            assign rows[g]     = row_reg;
        end
    endgenerate

    assign is_open_o = open_vec[bank_i];
    assign row_o     = rows[bank_i];

endmodule // sdci_bank_table

/* verilog/sdci_core.v */
// Functional notes
// - x8 part: sixteen banks in four groups of four.
// - x16 part: eight banks in two groups of four.
// - each access moves eight n-bit beats, two per clock, over four clocks.
// - bursts run eight beats, or four when chopped, from the start column; the code sends the low byte first whatever the column.
// - ACTIVE must open a row before READ or WRITE to that bank.
// - ACTIVE takes bank group from BG, bank from BA, row from A.
// - x16 uses only BG0 as bank group select.
// - READ/WRITE take column from address; A10 requests auto precharge.
// - with on-the-fly enabled, A12 picks chop four or burst eight.
// - write forms WR, WRS4, WRS8, auto-precharge forms, optional CRC.
// - refresh covers normal and fine grain; long and short calibration exist.
// - third mode register bits 3 and 4 default to zero.
// - fourth mode register bits 1, 8:6, 13, 5 default to zero.
// - fifth mode register parity latency bits 2:0 default to zero.
// - termination stays high impedance until clock enable registered high.
//
// Purpose: command decode, bank/row tracking, burst timing and mode defaults
// Assumes: command pins are synchronous to clk_i; dram reset pin is resetn_i
// Notes:   ck_i is sampled as a link clock; beats advance on both its edges
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "sdci_defines.vh"

module sdci_core #(
    parameter X16      = 0,
    parameter DQ_W     = 8,
    parameter COL_W    = 10,
    parameter ROW_W    = 18
) (
    input  wire              clk_i,
    input  wire              resetn_i,
    input  wire              ck_i,
    input  wire              cke_i,
    input  wire              boundary_scan_enable_i,
    input  wire [3:0]        cmd_i,
    input  wire [1:0]        bg_i,
    input  wire [1:0]        ba_i,
    input  wire [17:0]       addr_i,
    input  wire              crc_en_i,
    input  wire [DQ_W*8-1:0] wdata_i,
    input  wire [DQ_W*8-1:0] rdata_i,
    output reg               core_rd_o,
    output reg               core_wr_o,
    output reg  [3:0]        core_bank_o,
    output reg  [ROW_W-1:0]  core_row_o,
    output reg  [COL_W-1:0]  core_col_o,
    output reg  [DQ_W*8-1:0] core_wdata_o,
    output reg  [DQ_W-1:0]   dq_o,
    output reg               dq_oe_o,
    output reg               burst_busy_o,
    output reg               burst_chop_o,
    output reg               auto_pre_o,
    output reg               write_crc_o,
    output reg               refresh_o,
    output reg               zq_long_o,
    output reg               zq_short_o,
    output reg               odt_hiz_o,
    output reg               proto_err_o,
    output reg               nop_seen_o,
    output reg  [17:0]       third_mode_register_o,
    output reg  [17:0]       fourth_mode_register_o,
    output reg  [17:0]       fifth_mode_register_o
);

    localparam NBANK = X16 ? 8 : 16;
    localparam BIDLE = 2'h0;
    localparam BRUN  = 2'h1;

    // ==========================================================
    // link clock and boundary-scan synchronisers
    reg [1:0] ck_sync_reg;
    reg       ck_last_reg;
    reg [1:0] ten_sync_reg;
    // first stage feeds only the second stage
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ck_sync_reg  <= 2'h0;
            ck_last_reg  <= 1'b0;
            ten_sync_reg <= 2'h0;
        end else begin
            ck_sync_reg  <= {ck_sync_reg[0], ck_i};
            ck_last_reg  <= ck_sync_reg[1];
            ten_sync_reg <= {ten_sync_reg[0], boundary_scan_enable_i};
        end
    end
    // every transition of ck is one pin beat, so two per clock period
    wire ck_edge = ck_sync_reg[1] ^ ck_last_reg;
    wire scan_mode = ten_sync_reg[1];

    // ==========================================================
    // command qualification
    // commands only count once cke has been seen high after reset
    reg  cke_seen_reg;
    wire cmd_live = cke_seen_reg && cke_i && !scan_mode;
    wire is_act   = cmd_live && (cmd_i == `SDCI_CMD_ACT);
    wire is_rd    = cmd_live && (cmd_i == `SDCI_CMD_RD);
    wire is_wr    = cmd_live && (cmd_i == `SDCI_CMD_WR);
    wire is_pre   = cmd_live && (cmd_i == `SDCI_CMD_PRE);
    wire is_prea  = cmd_live && (cmd_i == `SDCI_CMD_PREA);
    wire is_mrs   = cmd_live && (cmd_i == `SDCI_CMD_MRS);

    // ==========================================================
    // bank index: x16 drops bg1
    wire [3:0] bank_idx = X16 ? {1'b0, bg_i[0], ba_i}
                              : {bg_i, ba_i};

    reg [1:0]  bl_mode_reg;
    reg        ap_close_reg;
    reg [3:0]  ap_bank_reg;

    wire        bank_open;
    wire [17:0] bank_row;

    sdci_bank_table #(
        .NBANK (NBANK),
        .BW    (4),
        .RW    (18)
    ) u_banks (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .open_i      (is_act),
        .close_i     (is_pre || ap_close_reg),
        .close_all_i (is_prea),
        .bank_i      (ap_close_reg ? ap_bank_reg : bank_idx),
        .row_i       (addr_i),
        .is_open_o   (bank_open),
        .row_o       (bank_row)
    );

    // access accepted if the bank_idx bank is open; while ap_close_reg is set, only if the ap_bank_reg bank is open
    wire rw_ok  = (is_rd || is_wr) && bank_open;
    wire rw_bad = (is_rd || is_wr) && !bank_open;

    // ==========================================================
    // burst length choice
    reg chop_next;
    always @* begin
        case (bl_mode_reg)
            `SDCI_BL_OTF:    chop_next = !addr_i[`SDCI_A_BC];
            `SDCI_BL_FIXED4: chop_next = 1'b1;
            default:         chop_next = 1'b0;
        endcase
    end

    // ==========================================================
    // burst engine
    reg [1:0]        bstate_reg;
    reg [3:0]        beat_reg;
    reg [3:0]        beats_reg;
    reg              bwrite_reg;
    reg [DQ_W*8-1:0] shift_reg;
    reg [DQ_W*8-1:0] wacc_reg;

    // a read or write that lands mid-burst restarts the engine; the controller
    // spaces bursts, and cutting the old one short is the simpler hazard
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bstate_reg   <= BIDLE;
            beat_reg     <= 4'h0;
            beats_reg    <= 4'h0;
            bwrite_reg   <= 1'b0;
            shift_reg    <= {DQ_W*8{1'b0}};
            wacc_reg     <= {DQ_W*8{1'b0}};
            core_rd_o    <= 1'b0;
            core_wr_o    <= 1'b0;
            core_bank_o  <= 4'h0;
            core_row_o   <= {ROW_W{1'b0}};
            core_col_o   <= {COL_W{1'b0}};
            core_wdata_o <= {DQ_W*8{1'b0}};
            dq_o         <= {DQ_W{1'b0}};
            dq_oe_o      <= 1'b0;
            burst_busy_o <= 1'b0;
            burst_chop_o <= 1'b0;
            auto_pre_o   <= 1'b0;
            write_crc_o  <= 1'b0;
            ap_close_reg <= 1'b0;
            ap_bank_reg  <= 4'h0;
        end else begin
            core_rd_o    <= 1'b0;
            core_wr_o    <= 1'b0;
            ap_close_reg <= 1'b0;
            if (rw_ok) begin
                // one 8n core word per access
                core_rd_o    <= is_rd;
                core_bank_o  <= bank_idx;
                core_row_o   <= bank_row[ROW_W-1:0];
                core_col_o   <= addr_i[COL_W-1:0];
                auto_pre_o   <= addr_i[`SDCI_A_AP];
                write_crc_o  <= is_wr && crc_en_i;
                burst_chop_o <= chop_next;
                beats_reg    <= chop_next ? `SDCI_BURST4 : `SDCI_BURST8;
                beat_reg     <= 4'h0;
                bwrite_reg   <= is_wr;
                shift_reg    <= rdata_i;
                wacc_reg     <= wdata_i;
                bstate_reg   <= BRUN;
                burst_busy_o <= 1'b1;
                dq_oe_o      <= is_rd;
            end else begin
                case (bstate_reg)
                    BIDLE: begin
                        dq_oe_o <= 1'b0;
                    end
                    BRUN: begin
                        if (ck_edge) begin
                            // beats leave low byte first, whatever the start column
                            dq_o      <= shift_reg[DQ_W-1:0];
                            shift_reg <= shift_reg >> DQ_W;
                            beat_reg  <= beat_reg + 4'h1;
                            if (beat_reg == beats_reg - 4'h1) begin
                                bstate_reg   <= BIDLE;
                                burst_busy_o <= 1'b0;
                                dq_oe_o      <= 1'b0;
                                core_wr_o    <= bwrite_reg;
                                core_wdata_o <= wacc_reg;
                                ap_close_reg <= auto_pre_o;
                                ap_bank_reg  <= core_bank_o;
                            end
                        end
                    end
                    default: begin
                        bstate_reg <= BIDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // mode registers: defaults on reset, loaded by mode register set
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            third_mode_register_o  <= `SDCI_MR3_RST;
            fourth_mode_register_o <= `SDCI_MR4_RST;
            fifth_mode_register_o  <= `SDCI_MR5_RST;
            bl_mode_reg            <= `SDCI_BL_FIXED8;
        end else if (is_mrs) begin
            case ({bg_i[0], ba_i})
                3'h0: bl_mode_reg            <= addr_i[`SDCI_MR0_BL_HI:`SDCI_MR0_BL_LO];
                3'h3: third_mode_register_o  <= addr_i;
                3'h4: fourth_mode_register_o <= addr_i;
                3'h5: fifth_mode_register_o  <= addr_i;
                default: bl_mode_reg <= bl_mode_reg;
            endcase
        end
    end

    // ==========================================================
    // cke history, termination, side commands and error flags
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cke_seen_reg <= 1'b0;
            odt_hiz_o    <= 1'b1;
            refresh_o    <= 1'b0;
            zq_long_o    <= 1'b0;
            zq_short_o   <= 1'b0;
            proto_err_o  <= 1'b0;
            nop_seen_o   <= 1'b0;
        end else begin
            if (cke_i) begin
                cke_seen_reg <= 1'b1;
                odt_hiz_o    <= 1'b0;
            end
            refresh_o   <= cmd_live && (cmd_i == `SDCI_CMD_REF);
            zq_long_o   <= cmd_live && (cmd_i == `SDCI_CMD_ZQCL);
            zq_short_o  <= cmd_live && (cmd_i == `SDCI_CMD_ZQCS);
            proto_err_o <= rw_bad;
            // stray nop is reported, not acted on
            nop_seen_o  <= cmd_live && (cmd_i == `SDCI_CMD_NOP);
        end
    end

endmodule // sdci_core

/* verilog/sdci_defines.vh */
// Purpose: shared constants for the sdram command and init block
// Assumes: included by bare name by sdci_core, the bench and the property checker
// Notes:   command codes are the decoded form presented on cmd_i
`ifndef SDCI_DEFINES_VH
`define SDCI_DEFINES_VH

// ==========================================================
// command codes (4 bits)
`define SDCI_CMD_DES     4'h0
`define SDCI_CMD_NOP     4'h1
`define SDCI_CMD_ACT     4'h2
`define SDCI_CMD_RD      4'h3
`define SDCI_CMD_WR      4'h4
`define SDCI_CMD_PRE     4'h5
`define SDCI_CMD_PREA    4'h6
`define SDCI_CMD_REF     4'h7
`define SDCI_CMD_ZQCL    4'h8
`define SDCI_CMD_ZQCS    4'h9
`define SDCI_CMD_MRS     4'hA

// ==========================================================
// address bit positions
`define SDCI_A_AP        10
`define SDCI_A_BC        12

// ==========================================================
// mode register field positions
`define SDCI_MR3_GEAR    3
`define SDCI_MR3_PDA     4
`define SDCI_MR4_MPS     1
`define SDCI_MR4_SPPR    5
`define SDCI_MR4_CAL_LO  6
`define SDCI_MR4_CAL_HI  8
`define SDCI_MR4_HPPR    13
`define SDCI_MR5_PAR_LO  0
`define SDCI_MR5_PAR_HI  2
`define SDCI_MR0_BL_LO   0
`define SDCI_MR0_BL_HI   1

// ==========================================================
// reset values of mode registers
`define SDCI_MR0_RST     18'h00000
`define SDCI_MR3_RST     18'h00000
`define SDCI_MR4_RST     18'h00000
`define SDCI_MR5_RST     18'h00000
`define SDCI_BL_FIXED8   2'h0
`define SDCI_BL_OTF      2'h1
`define SDCI_BL_FIXED4   2'h2

// ==========================================================
// timing: clock period in ps and beat counts
`define SDCI_CLK_PS      20000
`define SDCI_BURST8      4'h8
`define SDCI_BURST4      4'h4

`endif
